/* File: design/irq_route.sv */
// Contract
// R1: among requests at the same level in the same cycle the lower vector number is granted.
// R2: with the transfer service enabled on a shared level register, either source starts the service.
// R3: while the transfer service runs, every request other than the starting one is masked.
// R4: software should disable one of two requests sharing a level register when using the service.
// R5: a source pair on one level register has its flag cleared by the service's clear strobe.
// R6: the micro transfer clear strobe clears both flags of a shared vector; software polls the other.
// R7: stop-capable sources get their flag cleared and also a stop request issued.
// R8: conditionally available sources use the service only when their level-register partner is unused.
// R9: function line 1 carries endpoint 0 in/out, line 2 carries endpoints 1-5.
// R10: function line 3 merges suspend, frame start, bus reset, wakeup, config change; line 4 the aux event.
// R11: host line 1 merges disconnect, connect change, reset done, remote wakeup; line 2 frame start and done.
// R12: in host operation only micro transfer channels 2 and 3 of function line 2 are usable.
// R13: in host operation only endpoints 1 and 2 remain usable.
// R14: each request flag stays set until a clear strobe or software clears it.
`timescale 1ns/1ps
`include "irq_route_params.svh"
module irq_route
    import irq_route_pkg::*;
(
    input  wire logic                                      core_clk_i,
    input  wire logic                                      arst_n_i,
    input  wire usb_fn_evt_s                               fn_evt_i,
    input  wire usb_host_evt_s                             host_evt_i,
    input  wire logic                                      host_mode_i,
    input  wire logic [3:0]                                gen_evt_i,
    input  wire logic [`NUM_LVL_REGS-1:0][`LVL_W-1:0]      level_i,
    input  wire logic [`NUM_LVL_REGS-1:0]                  ats_en_i,
    input  wire logic [`NUM_FLAGS-1:0]                     req_en_i,
    input  wire logic [`NUM_FLAGS-1:0]                     sw_clr_i,
    input  wire logic [`NUM_SLOTS-1:0]                     dma_clr_i,
    input  wire logic                                      ats_clr_i,
    output logic                                           irq_req_o,
    output logic [7:0]                                     irq_vector_o,
    output logic [`LVL_W-1:0]                              irq_level_o,
    output logic                                           ats_start_o,
    output logic [7:0]                                     ats_vector_o,
    output logic                                           ats_busy_o,
    output logic                                           ats_stop_o,
    output logic [`NUM_FLAGS-1:0]                          flags_o,
    output logic [4:0]                                     ep_usable_o,
    output logic [4:0]                                     chan_usable_o
);
    ctrl_s                  st_r;
    ctrl_s                  st_nxt;
    logic [`NUM_FLAGS-1:0]  set_v;
    logic [`NUM_FLAGS-1:0]  clr_v;
    logic [`NUM_FLAGS-1:0]  flag_v;
    logic [`NUM_SLOTS-1:0]  slot_req;
    logic [4:0]             ep_mask;
    logic                   arb_vld;
    logic [2:0]             arb_slot;
    logic [`LVL_W-1:0]      arb_lvl;

    // ==========================================================
    // usb event grouping onto lines
    // ==========================================================
    assign ep_mask       = host_mode_i ? `EP_HOST_MASK : `EP_ALL_MASK; // R13
    assign ep_usable_o   = ep_mask; // R13
    assign chan_usable_o = host_mode_i ? `CHAN_HOST_MASK : `CHAN_ALL_MASK; // R12

    always_comb begin
        set_v = '0;
        set_v[2*`SLOT_FN_EP0]    = fn_evt_i.ep0_in | fn_evt_i.ep0_out; // R9
        set_v[2*`SLOT_FN_EPX]    = |(fn_evt_i.ep_data & ep_mask); // R9 R13
        set_v[2*`SLOT_FN_BUS]    = fn_evt_i.suspend_detect_event | fn_evt_i.frame_start
                                 | fn_evt_i.bus_reset_detect_event | fn_evt_i.wakeup_event
                                 | fn_evt_i.config_change_event; // R10
        set_v[2*`SLOT_FN_AUX]    = fn_evt_i.function_aux_event; // R10
        set_v[2*`SLOT_HOST_LINK] = host_evt_i.host_disconnect_event | host_evt_i.host_connect_change_event
                                 | host_evt_i.host_bus_reset_done_event
                                 | host_evt_i.host_remote_wakeup_event; // R11
        set_v[2*`SLOT_HOST_XFER] = host_evt_i.host_frame_start_event
                                 | host_evt_i.host_transfer_done_event; // R11
        set_v[`NUM_FLAGS-1:2*`SLOT_GEN_BASE] = gen_evt_i;
    end

    // ==========================================================
    // request flags
    // ==========================================================
    // every clear source ends up here; the cell lets a set win
    always_comb begin
        clr_v = sw_clr_i;
        for (int s = 0; s < `NUM_SLOTS; s++) begin
            if (dma_clr_i[s]) begin
                clr_v[2*s]   = 1'b1; // R6
                clr_v[2*s+1] = 1'b1; // R6
            end
        end
        if (st_r.state == ST_SERVICE && ats_clr_i) begin
            clr_v[{st_r.act_slot, 1'b0}] = 1'b1; // R5
            clr_v[{st_r.act_slot, 1'b1}] = 1'b1; // R5
        end
    end

    genvar g;
    generate
        for (g = 0; g < `NUM_FLAGS; g++) begin : gen_flag
            irq_flag_cell u_cell (
                .core_clk_i (core_clk_i),
                .arst_n_i   (arst_n_i),
                .set_i      (set_v[g]),
                .clr_i      (clr_v[g]),
                .flag_o     (flag_v[g])
            ); // R14
        end
    endgenerate

    assign flags_o = flag_v;

    // ==========================================================
    // arbitration
    // ==========================================================
    // a disabled source keeps its flag for polling but never requests
    always_comb begin
        for (int s = 0; s < `NUM_SLOTS; s++) begin
            slot_req[s] = (flag_v[2*s] & req_en_i[2*s]) | (flag_v[2*s+1] & req_en_i[2*s+1]);
        end
    end

    always_comb begin
        logic [`LVL_W-1:0] lv;
        lv       = '0;
        arb_vld  = 1'b0;
        arb_slot = '0;
        arb_lvl  = `LVL_OFF;
        for (int s = 0; s < `NUM_SLOTS; s++) begin
            lv = level_i[s/2];
            // strict compare keeps the lower vector on a tie
            if (slot_req[s] && lv != `LVL_OFF && (!arb_vld || lv < arb_lvl)) begin // R1
                arb_vld  = 1'b1;
                arb_slot = 3'(s);
                arb_lvl  = lv;
            end
        end
    end

    // ==========================================================
    // service control
    // ==========================================================
    always_comb begin
        st_nxt             = st_r;
        st_nxt.start_pulse = 1'b0;
        st_nxt.stop_pulse  = 1'b0;
        unique case (st_r.state)
            ST_IDLE: begin
                st_nxt.irq_req   = arb_vld;
                st_nxt.irq_slot  = arb_slot;
                st_nxt.irq_level = arb_lvl;
                if (arb_vld && ats_en_i[arb_slot[2:1]]) begin // R2
                    st_nxt.state       = ST_SERVICE;
                    st_nxt.act_slot    = arb_slot;
                    st_nxt.start_pulse = 1'b1;
                    st_nxt.irq_req     = 1'b0; // R3
                end
            end
            ST_SERVICE: begin
                // all other requests wait until the service ends
                st_nxt.irq_req = 1'b0; // R3
                if (ats_clr_i) begin
                    st_nxt.state      = ST_IDLE;
                    st_nxt.stop_pulse = 1'((`STOP_CAP_MASK >> st_r.act_slot) & 8'h01); // R7
                end
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_r       <= '0;
            st_r.state <= ST_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign irq_req_o    = st_r.irq_req;
    assign irq_vector_o = `VEC_BASE + {5'h00, st_r.irq_slot};
    assign irq_level_o  = st_r.irq_level;
    assign ats_start_o  = st_r.start_pulse;
    assign ats_vector_o = `VEC_BASE + {5'h00, st_r.act_slot};
    assign ats_busy_o   = st_r.state == ST_SERVICE;
    assign ats_stop_o   = st_r.stop_pulse;

    // ==========================================================
    // checks
    // ==========================================================
    function automatic logic lower_tie(input logic [7:0] req, input logic [2:0] slot,
                                       input logic [`NUM_LVL_REGS-1:0][`LVL_W-1:0] lvl);
        logic hit;
        hit = 1'b0;
        for (int s = 0; s < `NUM_SLOTS; s++) begin
            if (3'(s) < slot && req[s] && lvl[s/2] == lvl[slot[2:1]]) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction : lower_tie

    chk_tie_lower_vec: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // R1
        $rose(irq_req_o) |-> !lower_tie($past(slot_req), irq_vector_o[2:0] - 3'h3, $past(level_i)))
        else $error("tie granted to higher vector");

    chk_service_start: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // R2
        !ats_busy_o && arb_vld && ats_en_i[arb_slot[2:1]] |=> ats_start_o && ats_busy_o)
        else $error("service did not start on shared request");

    chk_service_mask: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // R3
        ats_busy_o |-> !irq_req_o)
        else $error("request passed during service");

    chk_service_clear: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // R5
        ats_busy_o && ats_clr_i && set_v[{st_r.act_slot, 1'b0}] == 1'b0 && set_v[{st_r.act_slot, 1'b1}] == 1'b0
        |=> !flag_v[{$past(st_r.act_slot), 1'b0}] && !flag_v[{$past(st_r.act_slot), 1'b1}] && !ats_busy_o)
        else $error("service clear left flag set");

    chk_dma_both: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // R6
        dma_clr_i[`SLOT_GEN_BASE] && !set_v[12] && !set_v[13] |=> !flag_v[12] && !flag_v[13])
        else $error("dma clear missed a shared flag");

    chk_stop_issue: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // R7
        ats_busy_o && ats_clr_i |=> ats_stop_o == $past(st_r.act_slot[2] & st_r.act_slot[1]))
        else $error("stop request wrong at service end");

    chk_fn_lines: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // R9 R10
        (!$past(fn_evt_i.ep0_out) || flag_v[0]) && (!$past(fn_evt_i.function_aux_event) || flag_v[6]))
        else $error("function event not routed");

    chk_host_lines: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // R11
        (!$past(host_evt_i.host_remote_wakeup_event) || flag_v[8])
        && (!$past(host_evt_i.host_transfer_done_event) || flag_v[10]))
        else $error("host event not routed");

    chk_host_limits: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // R12 R13
        host_mode_i && fn_evt_i.ep_data[4:2] != 3'h0 && fn_evt_i.ep_data[1:0] == 2'h0 && !flag_v[2]
        |=> !flag_v[2] && chan_usable_o == `CHAN_HOST_MASK)
        else $error("host mode allowed extra endpoint or channel");
endmodule : irq_route

/* File: design/irq_route_params.svh */
`ifndef IRQ_ROUTE_PARAMS_SVH
`define IRQ_ROUTE_PARAMS_SVH

// vector number of slot 0 (first usb function line)
`define VEC_BASE        8'h0b
`define NUM_SLOTS       8
`define NUM_FLAGS       16
`define NUM_LVL_REGS    4
`define LVL_W           3
// level value that disables a request
`define LVL_OFF         3'h7
// slots that get a stop request when their service ends
`define STOP_CAP_MASK   8'hc0
// endpoints 1..5 usable: all in function mode, 1 and 2 in host mode
`define EP_ALL_MASK     5'h1f
`define EP_HOST_MASK    5'h03
// micro transfer channels 2..6 of the second line: only 2 and 3 in host mode
`define CHAN_ALL_MASK   5'h1f
`define CHAN_HOST_MASK  5'h03
`define SLOT_FN_EP0     3'h0
`define SLOT_FN_EPX     3'h1
`define SLOT_FN_BUS     3'h2
`define SLOT_FN_AUX     3'h3
`define SLOT_HOST_LINK  3'h4
`define SLOT_HOST_XFER  3'h5
// first of the two general slots, the stop-capable pair
`define SLOT_GEN_BASE   3'h6

`endif

/* File: design/irq_route_pkg.sv */
package irq_route_pkg;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b01,
        ST_SERVICE = 2'b10
    } svc_state_e;

    typedef struct packed {
        logic       ep0_in;
        logic       ep0_out;
        logic [4:0] ep_data;
        logic       suspend_detect_event;
        logic       frame_start;
        logic       bus_reset_detect_event;
        logic       wakeup_event;
        logic       config_change_event;
        logic       function_aux_event;
    } usb_fn_evt_s;

    typedef struct packed {
        logic host_disconnect_event;
        logic host_connect_change_event;
        logic host_bus_reset_done_event;
        logic host_remote_wakeup_event;
        logic host_frame_start_event;
        logic host_transfer_done_event;
    } usb_host_evt_s;

    typedef struct packed {
        svc_state_e state;
        logic       irq_req;
        logic [2:0] irq_slot;
        logic [2:0] irq_level;
        logic [2:0] act_slot;
        logic       start_pulse;
        logic       stop_pulse;
    } ctrl_s;

    typedef struct packed {
        logic flag;
    } flag_cell_s;

endpackage : irq_route_pkg

/* File: design/irq_flag_cell.sv */
`timescale 1ns/1ps
module irq_flag_cell
    import irq_route_pkg::*;
(
    input  wire logic core_clk_i,
    input  wire logic arst_n_i,
    input  wire logic set_i,
    input  wire logic clr_i,
    output logic      flag_o
);
    flag_cell_s st_r;
    flag_cell_s st_nxt;

    // set wins over a clear in the same cycle so no event is lost
    always_comb begin
        st_nxt = st_r;
        if (set_i) begin
            st_nxt.flag = 1'b1;
        end else if (clr_i) begin
            st_nxt.flag = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign flag_o = st_r.flag;

    chk_flag_holds: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // R14
        flag_o && !clr_i |=> flag_o)
        else $error("request flag dropped without a clear");
endmodule : irq_flag_cell

/* File: tb/cpu_service_model.sv */
`timescale 1ns/1ps
// =====================================================
// service side: answers a running transfer service with one clear strobe
module cpu_service_model (
    input  wire logic       core_clk_i,
    input  wire logic       arst_n_i,
    input  wire logic       ats_busy_i,
    input  wire logic [7:0] delay_i,
    output logic            ats_clr_o
);
    logic [7:0] cnt_r;
    logic       clr_r;

    assign ats_clr_o = clr_r;

    // one-cycle strobe only while busy, so it is never taken in idle
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_r <= 8'h00;
            clr_r <= 1'b0;
        end else begin
            clr_r <= 1'b0;
            if (!ats_busy_i) begin
                cnt_r <= 8'h00;
            end else if (!clr_r) begin
                if (cnt_r == delay_i) begin
                    clr_r <= 1'b1;
                    cnt_r <= 8'h00;
                end else begin
                    cnt_r <= cnt_r + 8'h01;
                end
            end
        end
    end
endmodule : cpu_service_model

/* File: tb/irq_route_tb.sv */
`timescale 1ns/1ps
`include "irq_route_params.svh"
module irq_route_tb
    import irq_route_pkg::*;
;
    logic core_clk_i, arst_n_i, host_mode_i, ats_clr_i, irq_req_o, ats_start_o, ats_busy_o, ats_stop_o;
    usb_fn_evt_s fn_evt_i;
    usb_host_evt_s host_evt_i;
    logic [3:0] gen_evt_i, ats_en_i;
    logic [`NUM_LVL_REGS-1:0][`LVL_W-1:0] level_i;
    logic [15:0] req_en_i, sw_clr_i, flags_o;
    logic [7:0] dma_clr_i, irq_vector_o, ats_vector_o, delay, prev_vec;
    logic [2:0] irq_level_o;
    logic [4:0] ep_usable_o, chan_usable_o;
    logic [8:0] expq[$];
    logic [12:0] one;
    logic prev_req;
    int err_total, n_tests, cyc, stop_cnt, seed;

    irq_route uut (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .fn_evt_i(fn_evt_i), .host_evt_i(host_evt_i),
        .host_mode_i(host_mode_i), .gen_evt_i(gen_evt_i), .level_i(level_i), .ats_en_i(ats_en_i),
        .req_en_i(req_en_i), .sw_clr_i(sw_clr_i), .dma_clr_i(dma_clr_i), .ats_clr_i(ats_clr_i),
        .irq_req_o(irq_req_o), .irq_vector_o(irq_vector_o), .irq_level_o(irq_level_o),
        .ats_start_o(ats_start_o), .ats_vector_o(ats_vector_o), .ats_busy_o(ats_busy_o),
        .ats_stop_o(ats_stop_o), .flags_o(flags_o), .ep_usable_o(ep_usable_o), .chan_usable_o(chan_usable_o));

    cpu_service_model partner (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .ats_busy_i(ats_busy_o),
        .delay_i(delay), .ats_clr_o(ats_clr_i));

    // =====================================================
    // clock, timeout
    initial begin
        core_clk_i = 1'b0;
        forever #50 core_clk_i = ~core_clk_i;
    end

    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 4000) begin
            err_total++;
            complete_run();
        end
    end

    // =====================================================
    // monitor: each new request or service start takes the oldest note
    always @(negedge core_clk_i) begin
        if (ats_stop_o === 1'b1) stop_cnt++;
        if (ats_start_o === 1'b1 || (irq_req_o === 1'b1 && (prev_req !== 1'b1 || irq_vector_o !== prev_vec))) begin
            if (expq.size() == 0) check("unexpected result", 16'h0000, 16'hffff);
            else check(ats_start_o ? "service vector" : "irq vector", 16'(expq.pop_front()),
                       16'({ats_start_o, ats_start_o ? ats_vector_o : irq_vector_o}));
        end
        prev_req = irq_req_o;
        prev_vec = irq_vector_o;
    end

    // =====================================================
    // tasks
    task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : check

    task automatic evt(input logic [12:0] f, input logic [5:0] h, input logic [3:0] g);
        @(posedge core_clk_i);
        fn_evt_i <= usb_fn_evt_s'(f);
        host_evt_i <= usb_host_evt_s'(h);
        gen_evt_i <= g;
        @(posedge core_clk_i);
        fn_evt_i <= '0;
        host_evt_i <= '0;
        gen_evt_i <= 4'h0;
        #1;
    endtask : evt

    task automatic clr(input logic [15:0] sw, input logic [7:0] dm);
        @(posedge core_clk_i);
        sw_clr_i <= sw;
        dma_clr_i <= dm;
        @(posedge core_clk_i);
        sw_clr_i <= 16'h0000;
        dma_clr_i <= 8'h00;
        #1;
    endtask : clr

    task automatic wait_busy(input logic v);
        int t;
        t = 0;
        while (ats_busy_o !== v && t < 40) begin
            @(posedge core_clk_i);
            #1;
            t++;
        end
        check("busy", 16'(v), 16'(ats_busy_o));
    endtask : wait_busy

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : complete_run

    // =====================================================
    // main sequence
    initial begin
        seed = 93;
        arst_n_i = 1'b0;
        fn_evt_i = '0;
        host_evt_i = '0;
        gen_evt_i = 4'h0;
        host_mode_i = 1'b0;
        level_i = 12'hfff;
        ats_en_i = 4'h0;
        req_en_i = 16'hffff;
        sw_clr_i = 16'h0000;
        dma_clr_i = 8'h00;
        delay = 8'h00;
        repeat (10) @(posedge core_clk_i);
        arst_n_i <= 1'b1;
        #1;
        check("flags after reset", 16'h0000, flags_o);
        check("irq after reset", 16'h0000, 16'(irq_req_o));
        // every function and host event lands on its line's flag
        for (int i = 0; i < 13; i++) begin
            one = 13'h0000;
            one[i] = 1'b1;
            evt(one, 6'h00, 4'h0);
            check("fn flag", 16'h1 << (2 * (i == 0 ? 3 : i < 6 ? 2 : i < 11 ? 1 : 0)), flags_o);
            clr(16'hffff, 8'h00);
        end
        for (int i = 0; i < 6; i++) begin
            evt(13'h0000, 6'h1 << i, 4'h0);
            check("host flag", 16'h1 << (i < 2 ? 10 : 8), flags_o);
            clr(16'hffff, 8'h00);
        end
        $display("test event routing done");
        host_mode_i <= 1'b1;
        evt(13'h0100, 6'h00, 4'h0);
        check("ep3 in host mode", 16'h0000, flags_o);
        check("ep usable host", 16'h0003, 16'(ep_usable_o));
        check("chan usable host", 16'h0003, 16'(chan_usable_o));
        evt(13'h0080, 6'h00, 4'h0);
        check("ep2 in host mode", 16'h0004, flags_o);
        host_mode_i <= 1'b0;
        clr(16'hffff, 8'h00);
        check("ep usable fn", 16'h001f, 16'(ep_usable_o));
        check("chan usable fn", 16'h001f, 16'(chan_usable_o));
        $display("test host mode done");
        // ties and levels; the loser's flag must survive
        level_i <= {3'h7, 3'h1, 3'h3, 3'h2};
        expq.push_back(9'h00b);
        expq.push_back(9'h00c);
        evt(13'h1040, 6'h00, 4'h0);
        repeat (3) @(posedge core_clk_i);
        #1;
        check("irq level tie", 16'h0002, 16'(irq_level_o));
        clr(16'h0001, 8'h00);
        repeat (3) @(posedge core_clk_i);
        check("loser flag kept", 16'h0004, flags_o);
        clr(16'h0004, 8'h00);
        expq.push_back(9'h010);
        expq.push_back(9'h00d);
        evt(13'h0020, 6'h01, 4'h0);
        repeat (3) @(posedge core_clk_i);
        #1;
        check("irq level win", 16'h0001, 16'(irq_level_o));
        clr(16'h0400, 8'h00);
        repeat (3) @(posedge core_clk_i);
        clr(16'h0010, 8'h00);
        repeat (3) @(posedge core_clk_i);
        check("irq released", 16'h0000, 16'(irq_req_o));
        $display("test priority done");
        // transfer service on shared level register, prompt then slow partner
        level_i <= {3'h1, 3'h7, 3'h7, 3'h2};
        ats_en_i <= 4'h8;
        for (int k = 0; k < 2; k++) begin
            req_en_i <= ~(16'h1 << (k == 0 ? 14 : 13));
            delay <= (k == 0) ? 8'h00 : 8'(($random(seed) & 7) + 4);
            expq.push_back(k == 0 ? 9'h112 : 9'h111);
            evt(13'h0000, 6'h00, k == 0 ? 4'h8 : 4'h1);
            wait_busy(1'b1);
            expq.push_back(9'h00b);
            evt(13'h1000, 6'h00, 4'h0);
            check("irq masked while busy", 16'h0000, 16'(irq_req_o));
            wait_busy(1'b0);
            @(negedge core_clk_i);
            #1;
            check("stop pulses", 16'(k + 1), 16'(stop_cnt));
            check("service flags cleared", 16'h0001, flags_o);
            repeat (3) @(posedge core_clk_i);
            clr(16'h0001, 8'h00);
            repeat (2) @(posedge core_clk_i);
        end
        $display("test transfer service done");
        // micro transfer clear takes both flags of a vector
        ats_en_i <= 4'h0;
        level_i <= 12'hfff;
        req_en_i <= 16'hdfff;
        evt(13'h0000, 6'h00, 4'h3);
        check("shared flags set", 16'h3000, flags_o);
        clr(16'h0000, 8'h40);
        check("shared flags cleared", 16'h0000, flags_o);
        $display("test micro transfer clear done");
        check("notes left", 16'h0000, 16'(expq.size()));
        complete_run();
    end
endmodule : irq_route_tb
